// ---- hdl/l1_irq_pkg.sv ----
// constants for the command vector and layer one interrupt queue block
package l1_irq_pkg;
  // register byte offsets
  localparam logic [3:0]  CTRL_OFS        = 4'h0;
  localparam logic [3:0]  STATUS_OFS      = 4'h4;
  localparam logic [3:0]  VECTOR_OFS      = 4'h8;
  // control register fields and reset
  localparam int          CTRL_INTA_BIT   = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  // status register fields
  localparam int          STAT_CNT_LSB    = 0;
  localparam int          STAT_EMPTY_BIT  = 8;
  localparam int          STAT_FULL_BIT   = 9;
  // layer one vector layout
  localparam int          LAST_BIT        = 15;
  localparam int          VECTOR_SUBTYPE_BIT       = 14;
  localparam int          STATUS_LSB      = 7;
  localparam int          MID_LSB         = 5;
  localparam int          DETAIL_FIELD_LSB        = 0;
  localparam logic [1:0]  MID_FRAMER      = 2'h0;
  localparam logic [1:0]  MID_FDL         = 2'h1;
  localparam logic [1:0]  MID_MUX         = 2'h2;
  localparam logic [1:0]  MID_MAILBOX     = 2'h3;
  // type 0 framer status flag carrying the one-second tick
  localparam logic [6:0]  TICK_1HZ_FLAG   = 7'h04;
  // command vector layout
  localparam logic [3:0]  CMD_QUEUE_NUM   = 4'h8;
  localparam int          HDR_LSB         = 27;
  localparam logic [4:0]  TX_VEC_HDR      = 5'h12;
  localparam logic [4:0]  RX_VEC_HDR      = 5'h13;
  localparam int          TX_FAILED_BIT   = 17;
  localparam int          TX_DONE_BIT     = 16;
  localparam int          RX_DONE_BIT     = 16;
  // layer one fifo geometry
  localparam int          FIFO_DEPTH      = 16;
  localparam int          PTR_W           = 4;
  localparam int          NUM_SRC         = 4;
  localparam int          NUM_PORTS       = 32;
  // one-second timer: receive clock edges per second at the default rate
  localparam int          RX_CLK_HZ       = 1544000;
endpackage : l1_irq_pkg

// ---- hdl/interrupt_vector_queueing.sv ----
// command vector builder and layer one interrupt fifo with avalon slave
//
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - every command vector leaves on the command queue, number eight.
// - failed transmit init gives transmit vector with bit 17 set.
// - transmit init fails when more buffer is asked than remains.
// - transmit init fails when a threshold exceeds the requested buffer.
// - threshold sum must stay below buffer size; not checked here.
// - successful transmit init or off gives vector with bit 16 set.
// - successful receive init or off gives receive complete vector.
// - command vector bits 7:0 carry the affected channel number.
// - framer, data link, multiplexer and mailbox feed one fifo.
// - fifo readable from local bus and from pci host side.
// - local interrupt output high while fifo holds a vector.
// - fifo interrupt optionally forwarded to the pci interrupt pin.
// - vector is 16 bits: last, subtype, status, module, detail.
// - last flag 0 when more vectors remain, 1 on the final one.
// - module code 00 framer, 01 data link, 10 mux, 11 mailbox.
// - framer vector type chosen by bit 14: 0 type 0, 1 type I.
// - type 0 status bits 13..7 are framer events; bits 4..0 port.
// - one-second tick per port counted on that port's receive clock.
module interrupt_vector_queueing
  import l1_irq_pkg::*;
#(
  parameter int TICK_EDGES = RX_CLK_HZ
)(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // avalon-mm slave, local microprocessor side
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // pci host test read port
  input  wire logic                 pci_rd_req,
  output logic                      pci_rd_valid,
  output logic      [15:0]          pci_rd_data,
  // channel command outcomes
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_is_rx,
  input  wire logic                 cmd_is_init,
  input  wire logic [7:0]           channel_number,
  input  wire logic [15:0]          cmd_buf_req,
  input  wire logic [15:0]          cmd_buf_avail,
  input  wire logic [15:0]          cmd_fwd_thresh,
  input  wire logic [15:0]          cmd_refill_thresh,
  output logic                      cmd_vec_valid,
  output logic      [31:0]          cmd_vec_data,
  output logic      [3:0]           cmd_vec_queue,
  // t1/e1 framer events
  input  wire logic                 fr_valid,
  input  wire logic                 fr_type1,
  input  wire logic [6:0]           fr_status,
  input  wire logic [4:0]           fr_port,
  output logic                      fr_ready,
  input  wire logic [NUM_PORTS-1:0] rx_clk_in,
  // facility data link events
  input  wire logic                 fdl_valid,
  input  wire logic                 fdl_vector_subtype,
  input  wire logic [6:0]           fdl_status,
  input  wire logic [4:0]           fdl_detail_field,
  output logic                      fdl_ready,
  // multiplexer and ds2/ds3 framer events
  input  wire logic                 mux_valid,
  input  wire logic                 mux_vector_subtype,
  input  wire logic [6:0]           mux_status,
  input  wire logic [4:0]           mux_detail_field,
  output logic                      mux_ready,
  // mailbox events
  input  wire logic                 mbx_valid,
  input  wire logic                 mbx_vector_subtype,
  input  wire logic [6:0]           mbx_status,
  input  wire logic [4:0]           mbx_detail_field,
  output logic                      mbx_ready,
  // interrupt pins
  output logic                      local_irq_out,
  output logic                      inta_out
);

  // ---------------- command vectors ----------------
  logic        next_cmd_vec_valid;
  logic [31:0] next_cmd_vec_data;
  logic        tx_cmd_failed;

  always_comb
  begin
    tx_cmd_failed = 1'b0;
    next_cmd_vec_data = 32'h0000_0000;
    if (!cmd_is_rx && cmd_is_init)
    begin
      tx_cmd_failed = (cmd_buf_req > cmd_buf_avail) ||
                      (cmd_fwd_thresh > cmd_buf_req) ||
                      (cmd_refill_thresh > cmd_buf_req);
    end
    if (cmd_is_rx)
    begin
      next_cmd_vec_data[31:HDR_LSB] = RX_VEC_HDR;
      next_cmd_vec_data[RX_DONE_BIT] = 1'b1;
    end
    else
    begin
      next_cmd_vec_data[31:HDR_LSB] = TX_VEC_HDR;
      next_cmd_vec_data[TX_FAILED_BIT] = tx_cmd_failed;
      next_cmd_vec_data[TX_DONE_BIT] = !tx_cmd_failed;
    end
    next_cmd_vec_data[7:0] = channel_number;
    next_cmd_vec_valid = cmd_valid;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_vec_valid <= 1'b0;
      cmd_vec_data  <= 32'h0000_0000;
      cmd_vec_queue <= CMD_QUEUE_NUM;
    end
    else
    begin
      cmd_vec_valid <= next_cmd_vec_valid;
      cmd_vec_data  <= next_cmd_vec_data;
      cmd_vec_queue <= CMD_QUEUE_NUM;
    end
  end

  // ---------------- one-second tick per port ----------------
  logic [NUM_PORTS-1:0] rx_clk_prev;
  logic [NUM_PORTS-1:0] tick_hit;
  logic [NUM_PORTS-1:0] tick_pend;
  logic [NUM_PORTS-1:0] next_tick_pend;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_tick
      logic [31:0] edge_cnt;
      logic [31:0] next_edge_cnt;
      always_comb
      begin
        next_edge_cnt = edge_cnt;
        tick_hit[gp]  = 1'b0;
        if (rx_clk_in[gp] && !rx_clk_prev[gp])
        begin
          if (edge_cnt == 32'(TICK_EDGES - 1))
          begin
            next_edge_cnt = 32'h0000_0000;
            tick_hit[gp]  = 1'b1;
          end
          else
          begin
            next_edge_cnt = edge_cnt + 32'h0000_0001;
          end
        end
      end
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          edge_cnt <= 32'h0000_0000;
        end
        else
        begin
          edge_cnt <= next_edge_cnt;
        end
      end
    end
  endgenerate

  // ---------------- source slots and fifo ----------------
  logic [14:0]         slot_data [NUM_SRC];
  logic [14:0]         next_slot_data [NUM_SRC];
  logic [NUM_SRC-1:0]  slot_full;
  logic [NUM_SRC-1:0]  next_slot_full;
  logic [NUM_SRC-1:0]  src_valid;
  logic [NUM_SRC-1:0]  src_ready;
  logic [NUM_SRC-1:0]  next_src_ready;
  logic [14:0]         src_vec [NUM_SRC];
  logic [14:0]         mem [FIFO_DEPTH];
  logic [PTR_W-1:0]    wptr;
  logic [PTR_W-1:0]    rptr;
  logic [PTR_W:0]      count;
  logic [PTR_W-1:0]    next_wptr;
  logic [PTR_W-1:0]    next_rptr;
  logic [PTR_W:0]      next_count;
  logic                fifo_wr;
  logic [14:0]         fifo_wdata;
  logic                tick_load;
  logic [4:0]          tick_port;
  logic                local_pop;
  logic                pci_pop;
  logic                pci_pend;
  logic                next_pci_pend;
  logic [15:0]         head_vec;
  logic                found;

  assign src_valid = {mbx_valid, mux_valid, fdl_valid, fr_valid};
  assign src_vec[0] = {fr_type1, fr_status, MID_FRAMER, fr_port};
  assign src_vec[1] = {fdl_vector_subtype, fdl_status, MID_FDL, fdl_detail_field};
  assign src_vec[2] = {mux_vector_subtype, mux_status, MID_MUX, mux_detail_field};
  assign src_vec[3] = {mbx_vector_subtype, mbx_status, MID_MAILBOX, mbx_detail_field};

  // oldest vector with final-entry flag in front
  assign head_vec = {(count == (PTR_W+1)'(1)), mem[rptr]};

  always_comb
  begin
    fifo_wr    = 1'b0;
    fifo_wdata = slot_data[0];
    found      = 1'b0;
    tick_port  = 5'h00;
    next_slot_full = slot_full;
    for (int k = 0; k < NUM_SRC; k++)
    begin
      next_slot_data[k] = slot_data[k];
    end
    // fixed priority drain, framer first, one vector per cycle
    for (int k = 0; k < NUM_SRC; k++)
    begin
      if (slot_full[k] && !fifo_wr && (count != (PTR_W+1)'(FIFO_DEPTH)))
      begin
        fifo_wr = 1'b1;
        fifo_wdata = slot_data[k];
        next_slot_full[k] = 1'b0;
      end
    end
    for (int k = 0; k < NUM_SRC; k++)
    begin
      if (src_valid[k] && src_ready[k])
      begin
        next_slot_full[k] = 1'b1;
        next_slot_data[k] = src_vec[k];
      end
    end
    // lowest pending port tick fills a free framer slot
    for (int p = NUM_PORTS - 1; p >= 0; p--)
    begin
      if (tick_pend[p])
      begin
        found = 1'b1;
        tick_port = 5'(p);
      end
    end
    tick_load = found && !next_slot_full[0] && !fr_valid;
    if (tick_load)
    begin
      next_slot_full[0] = 1'b1;
      next_slot_data[0] = {1'b0, TICK_1HZ_FLAG, MID_FRAMER, tick_port};
    end
    next_src_ready = ~next_slot_full;
    next_tick_pend = tick_pend;
    if (tick_load)
    begin
      next_tick_pend[tick_port] = 1'b0;
    end
    next_tick_pend = next_tick_pend | tick_hit;
  end

  // ---------------- avalon slave and pops ----------------
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        take;

  always_comb
  begin
    take = (avs_read || avs_write) && avs_waitrequest;
    next_waitrequest = !take;
    next_readdata = 32'h0000_0000;
    next_ctrl = ctrl;
    local_pop = 1'b0;
    if (take && avs_read)
    begin
      if (avs_address == CTRL_OFS)
      begin
        next_readdata = ctrl;
      end
      else if (avs_address == STATUS_OFS)
      begin
        next_readdata[STAT_CNT_LSB +: PTR_W+1] = count;
        next_readdata[STAT_EMPTY_BIT] = (count == '0);
        next_readdata[STAT_FULL_BIT] =
          (count == (PTR_W+1)'(FIFO_DEPTH));
      end
      else if (avs_address == VECTOR_OFS)
      begin
        if (count != '0)
        begin
          next_readdata[15:0] = head_vec;
          local_pop = 1'b1;
        end
      end
    end
    if (take && avs_write && avs_address == CTRL_OFS)
    begin
      next_ctrl = {31'h0000_0000, avs_writedata[CTRL_INTA_BIT]};
    end
    // pci read waits for a cycle without a local pop
    pci_pop = (pci_pend || pci_rd_req) && !local_pop;
    next_pci_pend = (pci_pend || pci_rd_req) && local_pop;
    next_rptr = rptr;
    if ((local_pop || (pci_pop && count != '0)))
    begin
      next_rptr = rptr + PTR_W'(1);
    end
    next_wptr = fifo_wr ? wptr + PTR_W'(1) : wptr;
    next_count = count + (PTR_W+1)'(fifo_wr) -
                 (PTR_W+1)'(next_rptr != rptr);
  end

  always_ff @(posedge clk)
  begin
    if (fifo_wr)
    begin
      mem[wptr] <= fifo_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int k = 0; k < NUM_SRC; k++)
      begin
        slot_data[k] <= 15'h0000;
      end
      slot_full       <= '0;
      src_ready       <= '0;
      tick_pend       <= '0;
      rx_clk_prev     <= '0;
      wptr            <= '0;
      rptr            <= '0;
      count           <= '0;
      ctrl            <= CTRL_RESET;
      avs_readdata    <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      pci_pend        <= 1'b0;
      pci_rd_valid    <= 1'b0;
      pci_rd_data     <= 16'h0000;
      local_irq_out   <= 1'b0;
      inta_out        <= 1'b0;
    end
    else
    begin
      slot_data       <= next_slot_data;
      slot_full       <= next_slot_full;
      src_ready       <= next_src_ready;
      tick_pend       <= next_tick_pend;
      rx_clk_prev     <= rx_clk_in;
      wptr            <= next_wptr;
      rptr            <= next_rptr;
      count           <= next_count;
      ctrl            <= next_ctrl;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      pci_pend        <= next_pci_pend;
      pci_rd_valid    <= pci_pop;
      pci_rd_data     <= (count != '0) ? head_vec : 16'h0000;
      local_irq_out   <= (next_count != '0);
      inta_out        <= next_ctrl[CTRL_INTA_BIT] &&
                         (next_count != '0);
    end
  end

  assign fr_ready  = src_ready[0];
  assign fdl_ready = src_ready[1];
  assign mux_ready = src_ready[2];
  assign mbx_ready = src_ready[3];

endmodule : interrupt_vector_queueing

`default_nettype wire

// ---- bench/interrupt_vector_queueing_props.sv ----
// concurrent checks on the interrupt vector block ports
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_queueing_props
  import l1_irq_pkg::*;
#(
  parameter int TICK_EDGES = RX_CLK_HZ
)(
  // watched ports
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        pci_rd_req,
  input wire logic        pci_rd_valid,
  input wire logic        cmd_valid,
  input wire logic        cmd_is_rx,
  input wire logic        cmd_is_init,
  input wire logic [7:0]  channel_number,
  input wire logic [15:0] cmd_buf_req,
  input wire logic [15:0] cmd_buf_avail,
  input wire logic [15:0] cmd_fwd_thresh,
  input wire logic [15:0] cmd_refill_thresh,
  input wire logic        cmd_vec_valid,
  input wire logic [31:0] cmd_vec_data,
  input wire logic [3:0]  cmd_vec_queue,
  input wire logic        fdl_valid,
  input wire logic        fdl_ready,
  input wire logic        local_irq_out,
  input wire logic        inta_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic tx_init;
  assign tx_init = cmd_valid && !cmd_is_rx && cmd_is_init;
  property p_queue; cmd_vec_queue == CMD_QUEUE_NUM; endproperty
  a_queue: assert property (p_queue) else $error("bad queue");
  property p_cmd; cmd_valid |=> cmd_vec_valid; endproperty
  a_cmd: assert property (p_cmd) else $error("no vector");
  property p_channel_number;
    cmd_valid |=> cmd_vec_data[7:0] == $past(channel_number);
  endproperty
  a_channel_number: assert property (p_channel_number) else $error("bad channel");
  property p_fail; tx_init && cmd_buf_req > cmd_buf_avail |=> cmd_vec_data[17];
  endproperty
  a_fail: assert property (p_fail) else $error("no fail flag");
  property p_thr;
    tx_init && (cmd_fwd_thresh > cmd_buf_req || cmd_refill_thresh > cmd_buf_req)
      |=> cmd_vec_data[17] && !cmd_vec_data[16];
  endproperty
  a_thr: assert property (p_thr) else $error("no threshold fail");
  property p_rx; cmd_valid && cmd_is_rx |=> cmd_vec_data[17:16] == 2'h1;
  endproperty
  a_rx: assert property (p_rx) else $error("bad rx vector");
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bad waitrequest");
  property p_pci; pci_rd_req |-> ##[1:3] pci_rd_valid; endproperty
  a_pci: assert property (p_pci) else $error("no pci answer");
  property p_ready; fdl_valid && fdl_ready |=> !fdl_ready; endproperty
  a_ready: assert property (p_ready) else $error("ready held");
  property p_inta; inta_out |-> local_irq_out; endproperty
  a_inta: assert property (p_inta) else $error("inta alone");
  c_fail: cover property (cmd_vec_valid && cmd_vec_data[17]);
  c_inta: cover property (inta_out);
  c_pci: cover property (pci_rd_valid);
endmodule : interrupt_vector_queueing_props
bind interrupt_vector_queueing interrupt_vector_queueing_props
  #(.TICK_EDGES(TICK_EDGES)) props_u (.clk(clk), .srst(srst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .pci_rd_req(pci_rd_req), .pci_rd_valid(pci_rd_valid), .cmd_valid(cmd_valid),
  .cmd_is_rx(cmd_is_rx), .cmd_is_init(cmd_is_init),
  .channel_number(channel_number), .cmd_buf_req(cmd_buf_req),
  .cmd_buf_avail(cmd_buf_avail), .cmd_fwd_thresh(cmd_fwd_thresh),
  .cmd_refill_thresh(cmd_refill_thresh), .cmd_vec_valid(cmd_vec_valid),
  .cmd_vec_data(cmd_vec_data), .cmd_vec_queue(cmd_vec_queue),
  .fdl_valid(fdl_valid), .fdl_ready(fdl_ready),
  .local_irq_out(local_irq_out), .inta_out(inta_out));
`default_nettype wire

// ---- bench/pci_host_model.sv ----
// pci host reader that pops one vector per request
`timescale 1ns/10ps
`default_nettype none
module pci_host_model (
  // clock and trigger
  input  wire logic clk,
  input  wire logic go,
  // pci test read request
  output var  logic pci_rd_req
);
  // one-cycle pulse, launched just after the edge
  always_ff @(posedge clk) pci_rd_req <= go;
endmodule : pci_host_model
`default_nettype wire

// ---- bench/test_interrupt_vector_queueing.sv ----
// self-checking bench for the interrupt vector block
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_vector_queueing;
  import l1_irq_pkg::*;
  logic clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, pci_go = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, cmd_vec_data;
  logic avs_waitrequest, pci_rd_req, pci_rd_valid, cmd_vec_valid;
  logic local_irq_out, inta_out, cmd_valid = 1'b0, cmd_is_rx = 1'b0, cmd_is_init = 1'b0;
  logic [15:0] pci_rd_data, rq = 16'h0, av = 16'h0, fw = 16'h0, rf = 16'h0;
  logic [7:0] chn = 8'h0;
  logic [3:0] cmd_vec_queue, sv = 4'h0, st = 4'h0;
  wire logic [3:0] rdy;
  logic [3:0][6:0] ss = '0;
  logic [3:0][4:0] si = '0;
  logic [31:0] rx_clk_in = 32'h0;
  logic [31:0] exp_cmd[$], exp_bus[$];
  logic [15:0] exp_pci[$];
  logic [14:0] model[$];
  int n_errors = 0, n_checks = 0;
  always #4 clk = ~clk;
  interrupt_vector_queueing #(.TICK_EDGES(4)) dut_u (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pci_rd_req(pci_rd_req),
    .pci_rd_valid(pci_rd_valid), .pci_rd_data(pci_rd_data), .cmd_valid(cmd_valid),
    .cmd_is_rx(cmd_is_rx), .cmd_is_init(cmd_is_init), .channel_number(chn),
    .cmd_buf_req(rq), .cmd_buf_avail(av), .cmd_fwd_thresh(fw),
    .cmd_refill_thresh(rf), .cmd_vec_valid(cmd_vec_valid),
    .cmd_vec_data(cmd_vec_data), .cmd_vec_queue(cmd_vec_queue),
    .fr_valid(sv[0]), .fr_type1(st[0]), .fr_status(ss[0]), .fr_port(si[0]),
    .fr_ready(rdy[0]), .rx_clk_in(rx_clk_in), .fdl_valid(sv[1]), .fdl_vector_subtype(st[1]),
    .fdl_status(ss[1]), .fdl_detail_field(si[1]), .fdl_ready(rdy[1]), .mux_valid(sv[2]),
    .mux_vector_subtype(st[2]), .mux_status(ss[2]), .mux_detail_field(si[2]), .mux_ready(rdy[2]),
    .mbx_valid(sv[3]), .mbx_vector_subtype(st[3]), .mbx_status(ss[3]), .mbx_detail_field(si[3]),
    .mbx_ready(rdy[3]), .local_irq_out(local_irq_out), .inta_out(inta_out));
  pci_host_model host_u (.clk(clk), .go(pci_go), .pci_rd_req(pci_rd_req));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    if (cmd_vec_valid === 1'b1)
      check(cmd_vec_data, exp_cmd.size() ? exp_cmd.pop_front() : 'x);
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata, exp_bus.size() ? exp_bus.pop_front() : 'x);
    if (pci_rd_valid === 1'b1)
      check({16'h0, pci_rd_data}, exp_pci.size() ? exp_pci.pop_front() : 'x);
  end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    t = 0;
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++t < 50);
    if (t >= 50) n_errors++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    exp_bus.push_back(want);
    bus(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [15:0] head();
    // final-entry flag set when the popped vector is the last stored
    logic last;
    last = (model.size() == 1);
    return model.size() ? {last, model.pop_front()} : 16'h0;
  endfunction : head
  task automatic cmd(input logic x, i, input logic [15:0] q, a, f, r);
    logic [7:0] c;
    logic e;
    c = 8'($urandom);
    e = !x && i && (q > a || f > q || r > q);
    exp_cmd.push_back({x ? RX_VEC_HDR : TX_VEC_HDR, 9'h0, e, ~e, 8'h0, c});
    @(posedge clk);
    {cmd_valid, cmd_is_rx, cmd_is_init, chn, rq, av, fw, rf} <= {1'b1, x, i, c, q, a, f, r};
  endtask : cmd
  task automatic push(input logic [3:0] m);
    int k;
    @(posedge clk);
    for (k = 0; k < 4; k++)
    begin
      st[k] <= 1'($urandom);
      ss[k] <= 7'($urandom);
      si[k] <= 5'($urandom);
    end
    sv <= m;
    @(posedge clk);
    sv <= 4'h0;
    // priority framer first; mid follows source index
    for (k = 0; k < 4; k++) if (m[k]) model.push_back({st[k], ss[k], 2'(k), si[k]});
    k = 0;
    do @(posedge clk); while (rdy !== 4'hf && ++k < 50);
    if (k >= 50) n_errors++;
    repeat (2) @(posedge clk);
  endtask : push
  task automatic pci();
    exp_pci.push_back(head());
    @(posedge clk) pci_go <= 1'b1;
    @(posedge clk) pci_go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pci
  initial
  begin
    void'($urandom(32'h2a180d64));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    check({avs_waitrequest, cmd_vec_queue, local_irq_out}, 32'h30);
    cmd(0, 1, 100, 100, 40, 50);
    cmd(0, 1, 101, 100, 10, 10);
    cmd(0, 1, 50, 100, 51, 0);
    cmd(0, 1, 50, 100, 0, 51);
    cmd(0, 1, 50, 100, 40, 40);
    cmd(0, 1, 50, 50, 50, 0);
    cmd(0, 0, 200, 0, 300, 300);
    cmd(1, 1, 200, 0, 300, 0);
    cmd(1, 0, 0, 0, 0, 0);
    @(posedge clk) cmd_valid <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h1);
    rd(CTRL_OFS, 32'h1);
    rd(4'hc, 32'h0);
    push(4'hf);
    check({inta_out, local_irq_out}, 32'h3);
    rd(STATUS_OFS, 32'h4);
    repeat (3) rd(VECTOR_OFS, {16'h0, head()});
    pci();
    check({inta_out, local_irq_out}, 32'h0);
    rd(STATUS_OFS, 32'h100);
    rd(VECTOR_OFS, 32'h0);
    pci();
    repeat (8) @(posedge clk) rx_clk_in[3] <= ~rx_clk_in[3];
    model.push_back({1'b0, TICK_1HZ_FLAG, MID_FRAMER, 5'd3});
    bus(1'b1, CTRL_OFS, 32'h0);
    repeat (12) @(posedge clk);
    check({inta_out, local_irq_out}, 32'h1);
    rd(VECTOR_OFS, {16'h0, head()});
    repeat (6)
    begin
      push(4'($urandom) | 4'h1);
      while (model.size() > 1) rd(VECTOR_OFS, {16'h0, head()});
      pci();
    end
    repeat (4) @(posedge clk);
    check(exp_cmd.size() + exp_bus.size() + exp_pci.size(), 32'h0);
    summarize();
  end
  initial
  begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule : test_interrupt_vector_queueing
`default_nettype wire
